/* File: common/scb_pkg.sv */
`default_nettype none
package scb_pkg;
    // Register indices within one channel's set
    localparam logic [5:0] REG_RAW_VALUE     = 6'h00;
    localparam logic [5:0] REG_DIAGNOSTIC    = 6'h06;
    localparam logic [5:0] REG_COMMAND       = 6'h07;
    localparam logic [5:0] REG_MODULE_ID     = 6'h08;
    localparam logic [5:0] REG_FIRMWARE_REV  = 6'h09;
    localparam logic [5:0] REG_SHIFT_LENGTH  = 6'h0a;
    localparam logic [5:0] REG_CHANNEL_COUNT = 6'h0b;
    localparam logic [5:0] REG_MIN_DATA_LEN  = 6'h0c;
    localparam logic [5:0] REG_DATA_TYPE     = 6'h0d;
    localparam logic [5:0] REG_HARDWARE_REV  = 6'h10;
    localparam logic [5:0] REG_CODE_WORD     = 6'h1f;
    localparam logic [5:0] REG_FEATURE       = 6'h20;

    // Commands and constant contents
    localparam logic [15:0] CMD_TEACH_VOLATILE   = 16'h0201;
    localparam logic [15:0] CMD_TEACH_PERSISTENT = 16'h0202;
    localparam logic [15:0] RES_TEACH_VOLATILE   = 16'h0201;
    localparam logic [15:0] RES_TEACH_PERSISTENT = 16'h0202;
    localparam logic [15:0] SHIFT_LEN_ONE_CH     = 16'h0128;
    localparam logic [15:0] SHIFT_LEN_TWO_CH     = 16'h0228;
    localparam logic [15:0] MIN_DATA_LEN_VALUE   = 16'h2828;
    localparam logic [15:0] DATA_TYPE_ANALOG_IN  = 16'h0004;
    localparam logic [15:0] PERSIST_UNLOCK_CODE  = 16'h1235;
    localparam int          PROCESS_DATA_BYTES   = 5;

    // Reset values
    localparam logic [15:0] COMMAND_RESET   = 16'h0000;
    localparam logic [15:0] CODE_WORD_RESET = 16'h0000;
    localparam logic [15:0] FEATURE_RESET   = 16'h0000;

    // Feature register layout
    localparam int          TRIG_TYPE_LSB = 8;
    localparam int          TRIG_TYPE_MSB = 10;
    localparam logic [15:0] FEATURE_MASK  = 16'h0700;

    // Trigger type encodings
    localparam logic [2:0] TRIG_POST = 3'h0;
    localparam logic [2:0] TRIG_PRE  = 3'h1;
    localparam logic [2:0] TRIG_MID  = 3'h2;
    localparam logic [2:0] TRIG_FAST = 3'h3;

    // Sampling intervals
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int SLOW_INTERVAL_US = 100;
    localparam int FAST_INTERVAL_US = 10;
    localparam int SLOW_CYCLES      = SLOW_INTERVAL_US * 1000000 / CLK_PERIOD_PS;
    localparam int FAST_CYCLES      = FAST_INTERVAL_US * 1000000 / CLK_PERIOD_PS;
    localparam int SAMPLE_AMOUNT    = 100;

    // Capture sequencer states
    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_WAIT,
        CAP_RUN,
        CAP_TAIL
    } scb_cap_e;
endpackage
`default_nettype wire

/* File: hdl/scb_register_bank.sv */
// Operation
// - One full register set per channel, one or two channels by variant.
// - Index zero returns the channel's raw converter result.
// - Diagnostic register is reserved and reads zero.
// - Command 0x0201 teaches the volatile envelope and reads back 0x201.
// - Command 0x0202 teaches volatile and persistent envelopes, reads back 0x202.
// - Announced process-data shift length is always five bytes.
// - Module identifier is fixed, read-only, distinct per variant.
// - Firmware revision register returns a read-only revision code.
// - Shift length and channel count read 0x0128 or 0x0228 by variant.
// - Minimum data length always reads 0x2828.
// - Data type reads 0x0004, meaning analog input.
// - Hardware revision register returns the hardware revision code.
// - Without unlock code, user writes stay volatile only.
// - With unlock code 0x1235 stored, user writes also go persistent.
// - Code word clears at every restart.
// - Trigger type 000 starts recording at the trigger event.
// - Trigger type 001 records continuously, stops at the trigger event.
// - Trigger type 010 centres the trigger event in the recording.
// - Trigger type 011 is fast sampling at down to 10 us intervals.
// - Fast sampling starts only from the trigger input.
// - Fast sampling ignores the trigger unit input.
// - Fast sampling records only the first channel.
//
// The address-and-strobe port was decided locally.
`default_nettype none
module scb_register_bank #(
    parameter int          CHANNELS     = 2,
    parameter int          SLOW_CYCLES  = scb_pkg::SLOW_CYCLES,
    parameter int          SAMPLES      = scb_pkg::SAMPLE_AMOUNT,
    parameter logic [15:0] MODULE_ID_1  = 16'h0a01, // Arbitrary value
    parameter logic [15:0] MODULE_ID_2  = 16'h0a02, // Arbitrary value
    parameter logic [15:0] FIRMWARE_REV = 16'h0101, // Arbitrary value
    parameter logic [15:0] HARDWARE_REV = 16'h0000
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    // Register port: addr[6] selects channel, addr[5:0] the register
    input  wire logic [6:0]            reg_addr_i,
    input  wire logic [15:0]           reg_wdata_i,
    input  wire logic                  reg_write_i,
    input  wire logic                  reg_read_i,
    output logic      [15:0]           reg_rdata_o,
    // Converter results, one word per channel
    input  wire logic [CHANNELS*16-1:0] adc_raw_i,
    // Trigger sources
    input  wire logic                  trigger_pin_i,
    input  wire logic                  trigger_unit_i,
    input  wire logic                  capture_arm_i,
    // Recording control
    output logic      [CHANNELS-1:0]   record_enable_o,
    output logic                       sample_tick_o,
    output logic                       high_rate_capture_mode_o,
    // Envelope teach-in pulses per channel
    output logic      [CHANNELS-1:0]   teach_envelope_volatile_o,
    output logic      [CHANNELS-1:0]   teach_envelope_persistent_o,
    // User register storage requests
    output logic                       user_store_o,
    output logic                       user_persist_o,
    output logic      [6:0]            user_addr_o,
    output logic      [15:0]           user_data_o,
    // Announced process-data length
    output logic      [7:0]            process_bytes_o
);
    // Elaboration checks refuse sizes the counters and channel bit cannot serve
    if (CHANNELS < 1 || CHANNELS > 2) begin : g_chk_channels
        $error("CHANNELS must be 1 or 2");
    end
    if (SLOW_CYCLES < 2 || SLOW_CYCLES > 65535) begin : g_chk_slow
        $error("SLOW_CYCLES out of range");
    end
    if (SAMPLES < 2 || SAMPLES > 65535) begin : g_chk_samples
        $error("SAMPLES out of range");
    end

    localparam logic [15:0] SLOW_RELOAD = 16'(SLOW_CYCLES - 1);
    localparam logic [15:0] FAST_RELOAD = 16'(scb_pkg::FAST_CYCLES - 1);
    localparam logic [15:0] FULL_COUNT  = 16'(SAMPLES);
    localparam logic [15:0] HALF_COUNT  = 16'(SAMPLES / 2);

    // Per-channel state
    logic [15:0] raw_q     [CHANNELS];
    logic [15:0] command_q [CHANNELS];
    logic [15:0] code_q    [CHANNELS];
    logic [15:0] feature_q [CHANNELS];

    // Address decode
    wire       ch_sel    = (CHANNELS == 2) ? reg_addr_i[6] : 1'b0;
    wire       ch_valid  = (CHANNELS == 2) || !reg_addr_i[6];
    wire [5:0] idx       = reg_addr_i[5:0];
    wire       wr_cmd    = reg_write_i && ch_valid && (idx == scb_pkg::REG_COMMAND);
    wire       wr_code   = reg_write_i && ch_valid && (idx == scb_pkg::REG_CODE_WORD);
    wire       wr_feat   = reg_write_i && ch_valid && (idx == scb_pkg::REG_FEATURE);
    wire [15:0] variant_len = (CHANNELS == 2) ? scb_pkg::SHIFT_LEN_TWO_CH
                                              : scb_pkg::SHIFT_LEN_ONE_CH;
    wire [15:0] variant_id  = (CHANNELS == 2) ? MODULE_ID_2 : MODULE_ID_1;

    // Read multiplexer for the selected channel
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        if (!ch_valid) begin
            next_rdata = 16'h0000;
        end else if (idx == scb_pkg::REG_RAW_VALUE) begin
            next_rdata = raw_q[ch_sel];
        end else if (idx == scb_pkg::REG_DIAGNOSTIC) begin
            next_rdata = 16'h0000;
        end else if (idx == scb_pkg::REG_COMMAND) begin
            next_rdata = command_q[ch_sel];
        end else if (idx == scb_pkg::REG_MODULE_ID) begin
            next_rdata = variant_id;
        end else if (idx == scb_pkg::REG_FIRMWARE_REV) begin
            next_rdata = FIRMWARE_REV;
        end else if (idx == scb_pkg::REG_SHIFT_LENGTH || idx == scb_pkg::REG_CHANNEL_COUNT) begin
            next_rdata = variant_len;
        end else if (idx == scb_pkg::REG_MIN_DATA_LEN) begin
            next_rdata = scb_pkg::MIN_DATA_LEN_VALUE;
        end else if (idx == scb_pkg::REG_DATA_TYPE) begin
            next_rdata = scb_pkg::DATA_TYPE_ANALOG_IN;
        end else if (idx == scb_pkg::REG_HARDWARE_REV) begin
            next_rdata = HARDWARE_REV;
        end else if (idx == scb_pkg::REG_CODE_WORD) begin
            next_rdata = code_q[ch_sel];
        end else if (idx == scb_pkg::REG_FEATURE) begin
            next_rdata = feature_q[ch_sel];
        end
    end

    // Read data register, valid in the cycle after the strobe
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_read_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Per-channel register set and teach-in pulses
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < CHANNELS; c++) begin
                raw_q[c]     <= 16'h0000;
                command_q[c] <= scb_pkg::COMMAND_RESET;
                code_q[c]    <= scb_pkg::CODE_WORD_RESET;
                feature_q[c] <= scb_pkg::FEATURE_RESET;
            end
            teach_envelope_volatile_o   <= '0;
            teach_envelope_persistent_o <= '0;
        end else begin
            teach_envelope_volatile_o   <= '0;
            teach_envelope_persistent_o <= '0;
            for (int c = 0; c < CHANNELS; c++) begin
                raw_q[c] <= adc_raw_i[c*16 +: 16];
                if (wr_cmd && ch_sel == 1'(c)) begin
                    if (reg_wdata_i == scb_pkg::CMD_TEACH_VOLATILE) begin
                        command_q[c] <= scb_pkg::RES_TEACH_VOLATILE;
                        teach_envelope_volatile_o[c] <= 1'b1;
                    end else if (reg_wdata_i == scb_pkg::CMD_TEACH_PERSISTENT) begin
                        command_q[c] <= scb_pkg::RES_TEACH_PERSISTENT;
                        teach_envelope_volatile_o[c]   <= 1'b1;
                        teach_envelope_persistent_o[c] <= 1'b1;
                    end else begin
                        command_q[c] <= reg_wdata_i;
                    end
                end
                if (wr_code && ch_sel == 1'(c)) begin
                    code_q[c] <= reg_wdata_i;
                end
                if (wr_feat && ch_sel == 1'(c)) begin
                    feature_q[c] <= reg_wdata_i & scb_pkg::FEATURE_MASK;
                end
            end
        end
    end

    // User register storage requests; persistent only when unlocked
    wire unlocked = (code_q[ch_sel] == scb_pkg::PERSIST_UNLOCK_CODE);
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            user_store_o   <= 1'b0;
            user_persist_o <= 1'b0;
            user_addr_o    <= 7'h00;
            user_data_o    <= 16'h0000;
        end else begin
            user_store_o   <= wr_feat;
            user_persist_o <= wr_feat && unlocked;
            if (wr_feat) begin
                user_addr_o <= reg_addr_i;
                user_data_o <= reg_wdata_i & scb_pkg::FEATURE_MASK;
            end
        end
    end

    // Announced process-data length never depends on configuration
    assign process_bytes_o = 8'(scb_pkg::PROCESS_DATA_BYTES);

    // Trigger pin synchroniser
    logic trig_meta;
    logic trig_sync;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
        end else begin
            trig_meta <= trigger_pin_i;
            trig_sync <= trig_meta;
        end
    end

    // Mode from the first channel's trigger type field
    wire [2:0] trig_type = feature_q[0][scb_pkg::TRIG_TYPE_MSB:scb_pkg::TRIG_TYPE_LSB];
    wire       fast_mode = (trig_type == scb_pkg::TRIG_FAST);
    wire       trig_evt  = fast_mode ? trig_sync
                                     : (trig_sync || trigger_unit_i);
    assign high_rate_capture_mode_o = fast_mode;

    // Sample interval divider
    logic [15:0] div_q;
    wire         tick = (div_q == 16'h0000);
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= 16'h0000;
        end else if (tick) begin
            div_q <= fast_mode ? FAST_RELOAD : SLOW_RELOAD;
        end else begin
            div_q <= div_q - 16'h0001;
        end
    end
    assign sample_tick_o = tick;

    // Capture sequencer
    scb_pkg::scb_cap_e state_q;
    scb_pkg::scb_cap_e next_state;
    logic [15:0]       tail_q;
    logic [15:0]       next_tail;
    wire               wait_first = (trig_type == scb_pkg::TRIG_POST) || fast_mode;
    always_comb begin
        next_state = state_q;
        next_tail  = tail_q;
        case (state_q)
            scb_pkg::CAP_IDLE: begin
                if (capture_arm_i) begin
                    next_state = wait_first ? scb_pkg::CAP_WAIT : scb_pkg::CAP_RUN;
                end
            end
            scb_pkg::CAP_WAIT: begin
                if (trig_evt) begin
                    next_state = scb_pkg::CAP_TAIL;
                    next_tail  = FULL_COUNT;
                end
            end
            scb_pkg::CAP_RUN: begin
                if (trig_evt && trig_type == scb_pkg::TRIG_PRE) begin
                    next_state = scb_pkg::CAP_IDLE;
                end else if (trig_evt) begin
                    next_state = scb_pkg::CAP_TAIL;
                    next_tail  = HALF_COUNT;
                end
            end
            scb_pkg::CAP_TAIL: begin
                if (tick && tail_q == 16'h0001) begin
                    next_state = scb_pkg::CAP_IDLE;
                    next_tail  = 16'h0000;
                end else if (tick) begin
                    next_tail = tail_q - 16'h0001;
                end
            end
            default: begin
                next_state = scb_pkg::CAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= scb_pkg::CAP_IDLE;
            tail_q  <= 16'h0000;
        end else begin
            state_q <= next_state;
            tail_q  <= next_tail;
        end
    end

    // Recording enables; fast mode keeps only the first channel
    wire recording = (state_q == scb_pkg::CAP_RUN) || (state_q == scb_pkg::CAP_TAIL);
    always_comb begin
        record_enable_o = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            record_enable_o[c] = recording && (!fast_mode || c == 0);
        end
    end

    // Checks
    a_teach_vol_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (wr_cmd && !ch_sel && reg_wdata_i == scb_pkg::CMD_TEACH_VOLATILE)
        |=> teach_envelope_volatile_o[0] && !teach_envelope_persistent_o[0]
            && command_q[0] == scb_pkg::RES_TEACH_VOLATILE)
        else $error("volatile teach command not served");
    a_teach_flash_pulse: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (wr_cmd && !ch_sel && reg_wdata_i == scb_pkg::CMD_TEACH_PERSISTENT)
        |=> teach_envelope_volatile_o[0] && teach_envelope_persistent_o[0]
            && command_q[0] == scb_pkg::RES_TEACH_PERSISTENT)
        else $error("persistent teach command not served");
    a_min_len_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_read_i && ch_valid && idx == scb_pkg::REG_MIN_DATA_LEN)
        |=> reg_rdata_o == 16'h2828)
        else $error("minimum data length wrong");
    a_data_type_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_read_i && ch_valid && idx == scb_pkg::REG_DATA_TYPE)
        |=> reg_rdata_o == 16'h0004)
        else $error("data type wrong");
    a_shift_len_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_read_i && ch_valid && idx == scb_pkg::REG_CHANNEL_COUNT)
        |=> reg_rdata_o == ((CHANNELS == 2) ? 16'h0228 : 16'h0128))
        else $error("channel count wrong");
    a_volatile_only: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (wr_feat && code_q[ch_sel] != 16'h1235) |=> user_store_o && !user_persist_o)
        else $error("locked write went persistent");
    a_persist_write: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (wr_feat && code_q[ch_sel] == 16'h1235) |=> user_store_o && user_persist_o)
        else $error("unlocked write not persistent");
    a_reserved_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_feat && !ch_sel |=> (feature_q[0] & 16'hf8ff) == 16'h0000)
        else $error("reserved feature bits set");
    a_pre_stops: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == scb_pkg::CAP_RUN && trig_evt && trig_type == scb_pkg::TRIG_PRE)
        |=> state_q == scb_pkg::CAP_IDLE)
        else $error("pre-trigger did not stop");
    a_fast_ignores: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (fast_mode && state_q == scb_pkg::CAP_WAIT && !trig_sync && trigger_unit_i)
        |=> state_q == scb_pkg::CAP_WAIT)
        else $error("fast mode reacted to trigger unit");
    a_fast_interval: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (tick && fast_mode) |=> div_q == 16'(scb_pkg::FAST_CYCLES - 1))
        else $error("fast interval wrong");
    a_fast_one_chan: assert property (@(posedge clock_i) disable iff (!nrst_i)
        fast_mode |-> record_enable_o[CHANNELS-1:0] <= 1)
        else $error("fast mode records second channel");
    a_raw_read: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_read_i && !reg_addr_i[6] && idx == scb_pkg::REG_RAW_VALUE)
        |=> reg_rdata_o == $past(raw_q[0]))
        else $error("raw value read wrong");
    a_diag_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_read_i && idx == scb_pkg::REG_DIAGNOSTIC)
        |=> reg_rdata_o == 16'h0000)
        else $error("diagnostic register not zero");
    a_module_id: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (reg_read_i && ch_valid && idx == scb_pkg::REG_MODULE_ID)
        |=> reg_rdata_o == ((CHANNELS == 2) ? MODULE_ID_2 : MODULE_ID_1))
        else $error("module identifier wrong");
    a_post_tail: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == scb_pkg::CAP_WAIT && trig_evt)
        |=> state_q == scb_pkg::CAP_TAIL && tail_q == FULL_COUNT)
        else $error("post-trigger recording not started");
    a_mid_centre: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == scb_pkg::CAP_RUN && trig_evt && trig_type == scb_pkg::TRIG_MID)
        |=> state_q == scb_pkg::CAP_TAIL && tail_q == HALF_COUNT)
        else $error("mid-trigger tail length wrong");
    a_fast_arm: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == scb_pkg::CAP_IDLE && capture_arm_i && fast_mode)
        |=> state_q == scb_pkg::CAP_WAIT)
        else $error("fast mode did not wait for trigger input");
    c_post_capture: cover property (@(posedge clock_i) disable iff (!nrst_i)
        state_q == scb_pkg::CAP_WAIT ##1 state_q == scb_pkg::CAP_TAIL);
    c_mid_capture: cover property (@(posedge clock_i) disable iff (!nrst_i)
        state_q == scb_pkg::CAP_RUN ##1 state_q == scb_pkg::CAP_TAIL);
    c_unlocked_write: cover property (@(posedge clock_i) disable iff (!nrst_i) user_persist_o);
    c_teach_flash: cover property (@(posedge clock_i) disable iff (!nrst_i)
        teach_envelope_persistent_o[0]);
    c_pre_stop: cover property (@(posedge clock_i) disable iff (!nrst_i)
        state_q == scb_pkg::CAP_RUN ##1 state_q == scb_pkg::CAP_IDLE);
endmodule
`default_nettype wire

/* File: verification/scb_coupler_model.sv */
`default_nettype none
module scb_coupler_model #(
    parameter bit SPLIT_OK = 1'b1
) (
    // Clock
    input  wire logic        clock_i,
    // Register port towards the bank
    output logic      [6:0]  reg_addr_o,
    output logic      [15:0] reg_wdata_o,
    output logic             reg_write_o,
    output logic             reg_read_o,
    input  wire logic [15:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        reg_addr_o  = 7'h00;
        reg_wdata_o = 16'h0000;
        reg_write_o = 1'b0;
        reg_read_o  = 1'b0;
    end

    // One-cycle write; released lines show inverted values so stale data is not mistaken
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_write_o <= 1'b1;
        @(posedge clock_i);
        reg_write_o <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // One-cycle read; data taken in the following cycle only
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        d = 16'h0000;
        if (a[6] && !SPLIT_OK) begin
            return;
        end
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_read_o <= 1'b1;
        @(posedge clock_i);
        reg_read_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

/* File: verification/scb_register_bank_tb.sv */
`default_nettype none
module scb_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ID1 = 16'h0c31; // Arbitrary value
    localparam logic [15:0] ID2 = 16'h0c32; // Arbitrary value
    localparam logic [15:0] FW  = 16'h0107; // Arbitrary value
    localparam logic [15:0] HW  = 16'h0003;
    localparam int          LIMIT = 40000;
    logic        clock_i = 1'b0;
    logic        nrst_i  = 1'b0;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [15:0] rdata;
    logic [31:0] adc   = 32'h5678_1234;
    logic        pin   = 1'b0;
    logic        unit  = 1'b0;
    logic        arm   = 1'b0;
    logic [1:0]  rec;
    logic [1:0]  tv;
    logic [1:0]  tp;
    logic        tick;
    logic        fast;
    logic        ustore;
    logic        upersist;
    logic [6:0]  uaddr;
    logic [15:0] udata;
    logic [7:0]  pbytes;
    logic [15:0] d;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          cycles     = 0;

    // Clock and cycle ceiling
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            wrap_up();
        end
    end

    scb_coupler_model cpl (.clock_i(clock_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_write_o(wr_s), .reg_read_o(rd_s), .reg_rdata_i(rdata));

    scb_register_bank #(.CHANNELS(2), .SLOW_CYCLES(20), .SAMPLES(4), .MODULE_ID_1(ID1),
        .MODULE_ID_2(ID2), .FIRMWARE_REV(FW), .HARDWARE_REV(HW)) uut (
        .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata), .adc_raw_i(adc),
        .trigger_pin_i(pin), .trigger_unit_i(unit), .capture_arm_i(arm),
        .record_enable_o(rec), .sample_tick_o(tick), .high_rate_capture_mode_o(fast),
        .teach_envelope_volatile_o(tv), .teach_envelope_persistent_o(tp),
        .user_store_o(ustore), .user_persist_o(upersist), .user_addr_o(uaddr),
        .user_data_o(udata), .process_bytes_o(pbytes));

    // Compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rchk(input logic [6:0] a, input logic [15:0] e);
        cpl.rd(a, d);
        chk("rdata", e, d);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Cycles between two sample ticks
    task automatic gap(input int exp);
        int n;
        for (n = 0; n < 3000 && tick !== 1'b1; n++) begin
            @(posedge clock_i);
            #1;
        end
        for (n = 1; n < 3000; n++) begin
            @(posedge clock_i);
            #1;
            if (tick === 1'b1) break;
        end
        chk("tick_gap", 16'(exp), 16'(n));
    endtask

    // Arm, trigger and watch recording for one trigger type
    task automatic cap(input logic [2:0] m, input logic [1:0] pre, input logic [1:0] post);
        int  i;
        bit  f;
        f = (m == scb_pkg::TRIG_FAST);
        cpl.wr(7'h20, {5'h00, m, 8'h00});
        #1 chk("fast_mode", {15'h0000, f}, {15'h0000, fast});
        @(posedge clock_i) arm <= 1'b1;
        @(posedge clock_i) arm <= 1'b0;
        cyc(3);
        chk("rec_armed", {14'h0000, pre}, {14'h0000, rec});
        if (f) begin
            @(posedge clock_i) unit <= 1'b1;
            @(posedge clock_i) unit <= 1'b0;
            cyc(4);
            chk("rec_unit_ignored", 16'h0000, {14'h0000, rec});
        end
        @(posedge clock_i) begin
            pin  <= f;
            unit <= !f;
        end
        cyc(2);
        @(posedge clock_i) begin
            pin  <= 1'b0;
            unit <= 1'b0;
        end
        cyc(3);
        chk("rec_trig", {14'h0000, post}, {14'h0000, rec});
        for (i = 0; i < 10000 && rec !== 2'b00; i++) @(posedge clock_i);
        chk("rec_end", 16'h0000, {14'h0000, rec});
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        cyc(8);
        @(posedge clock_i) nrst_i <= 1'b1;
        chk("process_bytes", 16'h0005, {8'h00, pbytes});
        cpl.wr(7'h0c, 16'hffff);
        rchk(7'h00, 16'h1234);
        rchk(7'h40, 16'h5678);
        rchk(7'h06, 16'h0000);
        rchk(7'h08, ID2);
        rchk(7'h09, FW);
        rchk(7'h0a, 16'h0228);
        rchk(7'h4b, 16'h0228);
        rchk(7'h0c, 16'h2828);
        rchk(7'h0d, 16'h0004);
        rchk(7'h10, HW);
        rchk(7'h01, 16'h0000);
        cpl.wr(7'h07, 16'h0201);
        #1 chk("teach", 16'h0001, {12'h000, tp, tv});
        rchk(7'h07, 16'h0201);
        cpl.wr(7'h07, 16'h0202);
        #1 chk("teach", 16'h0005, {12'h000, tp, tv});
        rchk(7'h07, 16'h0202);
        cpl.wr(7'h47, 16'h0202);
        #1 chk("teach", 16'h000a, {12'h000, tp, tv});
        rchk(7'h47, 16'h0202);
        cpl.wr(7'h20, 16'hffff);
        #1 chk("store", 16'h0002, {14'h0000, ustore, upersist});
        chk("user_data", 16'h0700, udata);
        rchk(7'h20, 16'h0700);
        cpl.wr(7'h1f, 16'h1235);
        cpl.wr(7'h20, 16'h0000);
        #1 chk("store", 16'h0003, {14'h0000, ustore, upersist});
        chk("user_addr", 16'h0020, {9'h000, uaddr});
        @(posedge clock_i) nrst_i <= 1'b0;
        cyc(2);
        @(posedge clock_i) nrst_i <= 1'b1;
        rchk(7'h1f, 16'h0000);
        cpl.wr(7'h20, 16'h0000);
        #1 chk("store", 16'h0002, {14'h0000, ustore, upersist});
        gap(20);
        cap(scb_pkg::TRIG_POST, 2'b00, 2'b11);
        cap(scb_pkg::TRIG_PRE, 2'b11, 2'b00);
        cap(scb_pkg::TRIG_MID, 2'b11, 2'b11);
        cap(scb_pkg::TRIG_FAST, 2'b00, 2'b01);
        gap(scb_pkg::FAST_CYCLES);
        wrap_up();
    end
endmodule
`default_nettype wire
